// ### src/acref_pkg.sv
package acref_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ACREF_OFS_COL_CLK_SEL = 8'h60;
    localparam logic [7:0] ACREF_OFS_AUX_CLK_SEL = 8'h61;
    localparam logic [7:0] ACREF_OFS_REF_PWR = 8'h63;
    localparam logic ACREF_BANK_COL_CLK_SEL = 1'h1;
    localparam logic ACREF_BANK_AUX_CLK_SEL = 1'h1;
    localparam logic ACREF_BANK_REF_PWR = 1'h0;
    localparam logic [7:0] ACREF_RST_COL_CLK_SEL = 8'h00;
    localparam logic [7:0] ACREF_RST_AUX_CLK_SEL = 8'h00;
    localparam logic [7:0] ACREF_RST_REF_PWR = 8'h00;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int ACREF_NUM_COLS = 4;
    localparam int ACREF_COL_SEL_W = 2;
    localparam int ACREF_AUX_SEL_W = 3;
    localparam int ACREF_AUX_A_LSB = 0;
    localparam int ACREF_AUX_B_LSB = 3;
    localparam int ACREF_NUM_DIG_BLOCKS = 8;
    localparam int ACREF_DIV_W = 2;
    localparam int ACREF_BGT_BIT = 7;
    localparam int ACREF_BIAS_BIT = 6;
    localparam int ACREF_REF_LSB = 3;
    localparam int ACREF_PWR_LSB = 0;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] ACREF_SRC_FIXED_ONE = 2'h0;
    localparam logic [1:0] ACREF_SRC_FIXED_TWO = 2'h1;
    localparam logic [1:0] ACREF_SRC_AUX_A = 2'h2;
    localparam logic [1:0] ACREF_SRC_AUX_B = 2'h3;

    typedef enum logic [2:0] {
        ACREF_REF_HALF_BG = 3'h0,
        ACREF_REF_PIN_PAIR = 3'h1,
        ACREF_REF_HALF_HALF = 3'h2,
        ACREF_REF_2BG_BG = 3'h3,
        ACREF_REF_2BG_PIN = 3'h4,
        ACREF_REF_PIN_BG = 3'h5,
        ACREF_REF_RSVD6 = 3'h6,
        ACREF_REF_RSVD7 = 3'h7
    } acref_ref_t;

    localparam logic [2:0] ACREF_PWR_ALL_OFF = 3'h0;
    localparam logic [2:0] ACREF_PWR_SC_OFF_LOW = 3'h1;
    localparam logic [2:0] ACREF_PWR_SC_OFF_MED = 3'h2;
    localparam logic [2:0] ACREF_PWR_SC_OFF_HIGH = 3'h3;

    // decoded analog controls
    typedef struct packed {
        logic bandgapTest;
        logic rowZeroHighBias;
        logic rowsOneTwoHighBias;
        logic [2:0] refSource;
        logic refReserved;
        logic analogOn;
        logic switchedCapOn;
        logic [1:0] refPowerLevel;
    } acref_ctl_t;

endpackage : acref_pkg

// ### src/acref_col_div.sv
`timescale 1ns/1ps
// divide-by-four column clock stage
module acref_col_div #(
    parameter int DIV_W = 2
) (
    // selected source and reset
    input wire logic srcClk,
    input wire logic divRst,
    // divided clock
    output logic colClk
);
    logic [DIV_W-1:0] divCnt_r;

    // a free counter on the source; msb toggles every 2^(DIV_W-1) edges
    always_ff @(posedge srcClk) begin
        if (divRst) begin
            divCnt_r <= '0;
        end else begin
            divCnt_r <= divCnt_r + 1'b1;
        end
    end

    assign colClk = divCnt_r[DIV_W-1];
endmodule : acref_col_div

// ### src/acref_clock_ref_ctrl.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
// How it works
// - every analog block in one column is clocked from that column's single divided clock.
// - each column takes its clock from its own selected source via a 2-bit field.
// - select code 0 is fixed clock one, 1 fixed clock two, 2 aux clock a and 3 aux clock b.
// - the selected source runs through a divide-by-four stage per column.
// - the column clock select register sits at bank 1 offset 60h, two bits per column, reset zero.
// - the reference/power control register sits at bank 0 offset 63h, eight rw bits reset zero.
// - bit 7 is a factory bandgap test bit that software keeps at zero.
// - bit 6 picks low or high op-amp bias for the whole array.
// - bits 5:3 select the array reference, with codes 6 and 7 reserved.
// - bits 2:0 select array power: off, three reference power levels with sc off, or sc on.
// - row zero and rows one and two have separate bias outputs, both driven from bit 6.
// - each aux clock picks one of eight digital block clocks by a 3-bit field at bank 1 offset 61h.
module acref_clock_ref_ctrl
    import acref_pkg::*;
#(
    parameter int NUM_COLS = ACREF_NUM_COLS,
    parameter int NUM_DIG = ACREF_NUM_DIG_BLOCKS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic regBank,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    // clock sources
    input wire logic fixedSysClockOne,
    input wire logic fixedSysClockTwo,
    input wire logic [NUM_DIG-1:0] digBlockClk,
    // column clocks
    output logic [NUM_COLS-1:0] columnClock,
    // two-flop mclk copies of the aux clocks
    output logic auxClockA,
    output logic auxClockB,
    // decoded analog controls
    output acref_pkg::acref_ctl_t analogCtl
);
    import acref_pkg::*;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic bank, input logic [7:0] addr,
                                 input logic wantBank, input logic [7:0] wantAddr);
        hit = (bank == wantBank) && (addr == wantAddr);
    endfunction : hit

    logic hitColSel;
    logic hitAuxSel;
    logic hitRefPwr;
    assign hitColSel = hit(regBank, regAddr, ACREF_BANK_COL_CLK_SEL, ACREF_OFS_COL_CLK_SEL);
    assign hitAuxSel = hit(regBank, regAddr, ACREF_BANK_AUX_CLK_SEL, ACREF_OFS_AUX_CLK_SEL);
    assign hitRefPwr = hit(regBank, regAddr, ACREF_BANK_REF_PWR, ACREF_OFS_REF_PWR);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] colSel_r;
    logic [7:0] auxSel_r;
    logic [7:0] reference_power_level_r;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            colSel_r <= ACREF_RST_COL_CLK_SEL;
        end else if (regWrStb && hitColSel) begin
            colSel_r <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            auxSel_r <= ACREF_RST_AUX_CLK_SEL;
        end else if (regWrStb && hitAuxSel) begin
            auxSel_r <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reference_power_level_r <= ACREF_RST_REF_PWR;
        end else if (regWrStb && hitRefPwr) begin
            reference_power_level_r <= regWrData;
        end
    end

    // unmapped reads return zero; data stands only in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdStb) begin
            if (hitColSel) begin
                regRdData <= colSel_r;
            end else if (hitAuxSel) begin
                regRdData <= auxSel_r;
            end else if (hitRefPwr) begin
                regRdData <= reference_power_level_r;
            end else begin
                regRdData <= 8'h00;
            end
        end else begin
            regRdData <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // analog control decode
    // ------------------------------------------------------------
    logic [2:0] pwrField;
    logic [2:0] refField;
    assign pwrField = reference_power_level_r[ACREF_PWR_LSB +: 3];
    assign refField = reference_power_level_r[ACREF_REF_LSB +: 3];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            analogCtl <= '0;
        end else begin
            analogCtl.bandgapTest <= reference_power_level_r[ACREF_BGT_BIT];
            analogCtl.rowZeroHighBias <= reference_power_level_r[ACREF_BIAS_BIT];
            analogCtl.rowsOneTwoHighBias <= reference_power_level_r[ACREF_BIAS_BIT];
            analogCtl.refSource <= refField;
            analogCtl.refReserved <= (refField == ACREF_REF_RSVD6) || (refField == ACREF_REF_RSVD7);
            analogCtl.analogOn <= (pwrField != ACREF_PWR_ALL_OFF);
            analogCtl.switchedCapOn <= (pwrField > ACREF_PWR_SC_OFF_HIGH);
            case (pwrField)
                ACREF_PWR_SC_OFF_LOW: analogCtl.refPowerLevel <= 2'h1;
                ACREF_PWR_SC_OFF_MED: analogCtl.refPowerLevel <= 2'h2;
                ACREF_PWR_SC_OFF_HIGH: analogCtl.refPowerLevel <= 2'h3;
                default: analogCtl.refPowerLevel <= 2'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock muxing
    // ------------------------------------------------------------
    // the select fields are static configuration; glitches while they change are accepted
    logic auxA;
    logic auxB;
    assign auxA = digBlockClk[auxSel_r[ACREF_AUX_A_LSB +: ACREF_AUX_SEL_W]];
    assign auxB = digBlockClk[auxSel_r[ACREF_AUX_B_LSB +: ACREF_AUX_SEL_W]];

    // sampled copies for observation on mclk; the block clocks are foreign to mclk, so two flops
    logic auxSyncA_r;
    logic auxSyncB_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            auxSyncA_r <= 1'b0;
            auxSyncB_r <= 1'b0;
            auxClockA <= 1'b0;
            auxClockB <= 1'b0;
        end else begin
            auxSyncA_r <= auxA;
            auxSyncB_r <= auxB;
            auxClockA <= auxSyncA_r;
            auxClockB <= auxSyncB_r;
        end
    end

    function automatic logic pick_src(input logic [1:0] sel, input logic c1, input logic c2,
                                      input logic a, input logic b);
        case (sel)
            ACREF_SRC_FIXED_ONE: pick_src = c1;
            ACREF_SRC_FIXED_TWO: pick_src = c2;
            ACREF_SRC_AUX_A: pick_src = a;
            ACREF_SRC_AUX_B: pick_src = b;
            default: pick_src = c1;
        endcase
    endfunction : pick_src

    logic [NUM_COLS-1:0] colSrc;
    logic [NUM_COLS-1:0] colDiv;
    logic [NUM_COLS-1:0] divRstSync;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_COLS; gi++) begin : gCol
            assign colSrc[gi] = pick_src(colSel_r[gi*ACREF_COL_SEL_W +: ACREF_COL_SEL_W],
                                         fixedSysClockOne, fixedSysClockTwo, auxA, auxB);
            // reset reaches the divider through two flops on its own clock
            logic [1:0] rstPipe_r;
            always_ff @(posedge colSrc[gi]) begin
                rstPipe_r <= {rstPipe_r[0], sys_rst};
            end
            assign divRstSync[gi] = rstPipe_r[1];
            acref_col_div #(
                .DIV_W(ACREF_DIV_W)
            ) acref_col_div_inst (
                .srcClk(colSrc[gi]),
                .divRst(divRstSync[gi]),
                .colClk(colDiv[gi])
            );
        end
    endgenerate

    assign columnClock = colDiv;

endmodule : acref_clock_ref_ctrl

// ### tb/acref_clock_ref_ctrl_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// register and decode checks
// ------------------------------------------------------------
module acref_clock_ref_ctrl_properties
    import acref_pkg::*;
#(
    parameter int NUM_COLS = ACREF_NUM_COLS,
    parameter int NUM_DIG = ACREF_NUM_DIG_BLOCKS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic regBank,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    // clocks
    input wire logic fixedSysClockOne,
    input wire logic fixedSysClockTwo,
    input wire logic [NUM_DIG-1:0] digBlockClk,
    input wire logic [NUM_COLS-1:0] columnClock,
    input wire logic auxClockA,
    input wire logic auxClockB,
    // decode
    input wire acref_ctl_t analogCtl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire refWr = regWrStb && !regBank && regAddr == 8'h63;
    wire colWr = regWrStb && regBank && regAddr == 8'h60;
    AST_RD_IDLE: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero when idle");
    AST_COL_RW: assert property (colWr ##1 (regRdStb && regBank && regAddr == 8'h60)
        |=> regRdData == $past(regWrData, 2)) else $error("column select read back wrong");
    AST_REF_RW: assert property (refWr ##1 (regRdStb && !regBank && regAddr == 8'h63)
        |=> regRdData == $past(regWrData, 2)) else $error("ref power read back wrong");
    AST_UNMAPPED: assert property (regRdStb && regAddr == 8'h62 |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    AST_HOLD: assert property (!refWr |=> ##1 $stable(analogCtl))
        else $error("decode changed without write");
    AST_BGT: assert property (refWr |=> ##1 analogCtl.bandgapTest == $past(regWrData[7], 2))
        else $error("bandgap test bit wrong");
    AST_BIAS: assert property (refWr |=> ##1 analogCtl.rowZeroHighBias == $past(regWrData[6], 2))
        else $error("bias level wrong");
    AST_ROWS: assert property (analogCtl.rowsOneTwoHighBias == analogCtl.rowZeroHighBias)
        else $error("row bias mismatch");
    AST_REF: assert property (refWr |=> ##1 analogCtl.refSource == $past(regWrData[5:3], 2)
        && analogCtl.refReserved == ($past(regWrData[5:4], 2) == 2'h3)) else $error("reference decode wrong");
    AST_PWR: assert property (refWr |=> ##1 analogCtl.analogOn == ($past(regWrData[2:0], 2) != 3'h0)
        && analogCtl.switchedCapOn == $past(regWrData[2], 2)) else $error("power decode wrong");
    AST_PWR_LVL: assert property (refWr |=> ##1 analogCtl.refPowerLevel
        == ($past(regWrData[2], 2) ? 2'h0 : $past(regWrData[1:0], 2))) else $error("power level wrong");
endmodule : acref_clock_ref_ctrl_properties

bind acref_clock_ref_ctrl acref_clock_ref_ctrl_properties #(.NUM_COLS(NUM_COLS), .NUM_DIG(NUM_DIG))
    acref_clock_ref_ctrl_properties_inst (.mclk(mclk), .sys_rst(sys_rst), .regBank(regBank),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .fixedSysClockOne(fixedSysClockOne), .fixedSysClockTwo(fixedSysClockTwo),
    .digBlockClk(digBlockClk), .columnClock(columnClock), .auxClockA(auxClockA),
    .auxClockB(auxClockB), .analogCtl(analogCtl));

// ### tb/acref_clock_ref_ctrl_tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bench
// ------------------------------------------------------------
module acref_clock_ref_ctrl_tb_top;
    import acref_pkg::*;
    logic mclk, sys_rst, regBank, regWrStb, regRdStb, fixedSysClockOne, fixedSysClockTwo;
    logic auxClockA, auxClockB;
    logic [7:0] regAddr, regWrData, regRdData, digBlockClk;
    logic [3:0] columnClock;
    acref_ctl_t analogCtl;
    int errCount, cmpCount;
    time lastT [4];
    time per [4];
    logic [7:0] digQ1, digQ2;
    acref_clock_ref_ctrl acref_clock_ref_ctrl_inst (.mclk(mclk), .sys_rst(sys_rst), .regBank(regBank),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .fixedSysClockOne(fixedSysClockOne), .fixedSysClockTwo(fixedSysClockTwo),
        .digBlockClk(digBlockClk), .columnClock(columnClock), .auxClockA(auxClockA),
        .auxClockB(auxClockB), .analogCtl(analogCtl));
    // sources have distinct periods so a wrong select shows as a wrong column period
    initial begin mclk = 1'b0; forever #2 mclk = ~mclk; end
    initial begin fixedSysClockOne = 1'b0; forever #5 fixedSysClockOne = ~fixedSysClockOne; end
    initial begin fixedSysClockTwo = 1'b0; forever #6 fixedSysClockTwo = ~fixedSysClockTwo; end
    for (genvar i = 0; i < 8; i++) begin : g_dig
        // odd toggle times never meet an mclk edge, so sampling them is free of races
        initial begin digBlockClk[i] = 1'b0; #1; forever #(8 + 2 * i) digBlockClk[i] = ~digBlockClk[i]; end
    end
    always @(posedge mclk) begin
        digQ1 <= digBlockClk;
        digQ2 <= digQ1;
    end
    for (genvar k = 0; k < 4; k++) begin : g_per
        always @(posedge columnClock[k]) begin per[k] = $time - lastT[k]; lastT[k] = $time; end
    end
    function automatic time expPer(input logic [1:0] c, input logic [7:0] aux);
        case (c)
            2'h0: return 40;
            2'h1: return 48;
            2'h2: return 8 * (8 + 2 * aux[2:0]);
            default: return 8 * (8 + 2 * aux[5:3]);
        endcase
    endfunction : expPer
    task automatic fail(input string m);
        errCount++;
        $display("BAD %0t %s", $time, m);
    endtask : fail
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        cmpCount++;
        if (g !== e) fail("register data");
    endtask : chk8
    task automatic chkc(input acref_ctl_t g, input acref_ctl_t e);
        cmpCount++;
        if (g !== e) fail("decoded controls");
    endtask : chkc
    task automatic chkb(input logic g, input logic e);
        cmpCount++;
        if (g !== e) fail("aux clock copy");
    endtask : chkb
    task automatic chkt(input time g, input time e);
        cmpCount++;
        if (g !== e) fail("column period");
    endtask : chkt
    task automatic wr(input logic b, input logic [7:0] a, input logic [7:0] d);
        regBank <= b; regAddr <= a; regWrData <= d; regWrStb <= 1'b1;
        @(posedge mclk); regWrStb <= 1'b0;
    endtask : wr
    // read data stand one cycle only, then fall back to zero
    task automatic rd(input logic b, input logic [7:0] a, input logic [7:0] e);
        regBank <= b; regAddr <= a; regRdStb <= 1'b1;
        @(posedge mclk); regRdStb <= 1'b0;
        #1 chk8(regRdData, e);
        @(posedge mclk); #1 chk8(regRdData, 8'h00);
        @(posedge mclk);
    endtask : rd
    task automatic t_reset();
        rd(1'b1, 8'h60, 8'h00);
        rd(1'b0, 8'h63, 8'h00);
        rd(1'b1, 8'h61, 8'h00);
        chkc(analogCtl, '0);
    endtask : t_reset
    task automatic t_unmapped();
        wr(1'b0, 8'h60, 8'hff);
        @(posedge mclk);
        wr(1'b1, 8'h63, 8'hff);
        @(posedge mclk);
        wr(1'b1, 8'h62, 8'hff);
        rd(1'b1, 8'h60, 8'h00);
        rd(1'b0, 8'h63, 8'h00);
        rd(1'b0, 8'h60, 8'h00);
        rd(1'b1, 8'h62, 8'h00);
    endtask : t_unmapped
    task automatic t_reference_power_level();
        acref_ctl_t e;
        logic [2:0] r, p;
        for (int i = 0; i < 8; i++) begin
            r = i[2:0];
            p = ~r;
            wr(1'b0, 8'h63, {1'b0, r[0], r, p});
            rd(1'b0, 8'h63, {1'b0, r[0], r, p});
            e = '{1'b0, r[0], r[0], r, r[2] & r[1], p != 3'h0, p[2], p[2] ? 2'h0 : p[1:0]};
            chkc(analogCtl, e);
        end
    endtask : t_reference_power_level
    // aux sources are picked before columns use them
    task automatic t_cols();
        logic [7:0] sels [3] = '{8'he4, 8'h1b, 8'he4};
        logic [7:0] auxs [3] = '{8'hea, 8'hea, 8'h07};
        for (int j = 0; j < 3; j++) begin
            wr(1'b1, 8'h61, auxs[j]);
            rd(1'b1, 8'h61, auxs[j]);
            wr(1'b1, 8'h60, sels[j]);
            rd(1'b1, 8'h60, sels[j]);
            repeat (300) @(posedge mclk);
            for (int k = 0; k < 4; k++) chkt(per[k], expPer(sels[j][2*k+1 -: 2], auxs[j]));
            // the copies lag the chosen block clock by two mclk edges
            for (int n = 0; n < 40; n++) begin
                @(posedge mclk);
                #1 chkb(auxClockA, digQ2[auxs[j][2:0]]);
                chkb(auxClockB, digQ2[auxs[j][5:3]]);
            end
            @(posedge mclk);
        end
    endtask : t_cols
    task automatic testDone();
        if (errCount == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : testDone
    initial begin
        sys_rst = 1'b1; regBank = 1'b0; regAddr = 8'h00; regWrData = 8'h00;
        regWrStb = 1'b0; regRdStb = 1'b0; errCount = 0; cmpCount = 0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_unmapped();
        t_reference_power_level();
        t_cols();
        testDone();
    end
endmodule : acref_clock_ref_ctrl_tb_top
